// ### src/ipcs_map.vh
// Purpose: register map, field positions and mode codes of the i2c port control/status block
// Assumes: 32-bit axi4-lite slave, byte addresses, registers in the low byte of each word
// Notes:   definitions only
`ifndef IPCS_MAP_VH
`define IPCS_MAP_VH

// register byte offsets
`define IPCS_OFF_STATUS  8'h00
`define IPCS_OFF_CTRL    8'h04
`define IPCS_OFF_BUF     8'h08
`define IPCS_OFF_BAUD    8'h0C

// port_status fields
`define IPCS_ST_BF       0
`define IPCS_ST_UA       1
`define IPCS_ST_RW       2
`define IPCS_ST_S        3
`define IPCS_ST_P        4
`define IPCS_ST_DA       5

// port_control_one fields
`define IPCS_CT_WRITE_COLLISION_FLAG     7
`define IPCS_CT_OVF      6
`define IPCS_CT_EN       5
`define IPCS_CT_CKP      4

// mode_field codes
`define IPCS_MODE_S10_SP 4'hF
`define IPCS_MODE_S7_SP  4'hE
`define IPCS_MODE_FWMST  4'hB
`define IPCS_MODE_HWMST  4'h8
`define IPCS_MODE_S10    4'h7
`define IPCS_MODE_S7     4'h6

// reset values, bus answers and bits per byte
`define IPCS_RST_BYTE    8'h00
`define IPCS_RESP_OKAY   2'h0
`define IPCS_RESP_SLVERR 2'h2
`define IPCS_BITS_BYTE   4'h8

`endif

// ### src/ipcs_port.v
// Purpose: i2c serial port control and status registers with a minimal byte engine
// Assumes: pins synchronous to aclk, aclk is the oscillator clock, open-drain pins low-only
// Notes:   address matching and the second control register are outside this block
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "ipcs_map.vh"

module ipcs_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         pins_owned
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg        aw_have_reg;
  reg        w_have_reg;
  reg [7:0]  awaddr_reg;
  reg [7:0]  wbyte_reg;
  reg        wlane_reg;
  reg [1:0]  stat_wr_reg;
  reg        write_collision_flag_reg;
  reg        ovf_reg;
  reg        en_reg;
  reg        ckp_reg;
  reg [3:0]  mode_reg;
  reg [7:0]  buf_reg;
  reg [7:0]  baud_reg;
  reg        bf_reg;
  reg        ua_reg;
  reg        rw_reg;
  reg        s_reg;
  reg        p_reg;
  reg        da_reg;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg [3:0]  bitcnt_reg;
  reg [7:0]  shift_reg;
  reg        addr_ph_reg;
  reg        stx_reg;
  reg        mtx_reg;
  reg [1:0]  phase_reg;
  reg [7:0]  qcnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  wire slv = en_reg & ((mode_reg == `IPCS_MODE_S10_SP) | (mode_reg == `IPCS_MODE_S7_SP) |
                       (mode_reg == `IPCS_MODE_S10) | (mode_reg == `IPCS_MODE_S7));
  wire mst = en_reg & (mode_reg == `IPCS_MODE_HWMST);
  // firmware master and unlisted codes fall through: no slave or master engine runs
  wire ten_bit = mode_reg[0];

  // bus handshake terms
  wire wr_go = aw_have_reg & w_have_reg & ~bvalid;
  wire rd_go = arvalid & arready;
  wire sw_wr = wr_go & wlane_reg;
  wire wr_stat = sw_wr & (awaddr_reg == `IPCS_OFF_STATUS);
  wire wr_ctl = sw_wr & (awaddr_reg == `IPCS_OFF_CTRL);
  wire wr_buf = sw_wr & (awaddr_reg == `IPCS_OFF_BUF) & en_reg;
  wire wr_baud = sw_wr & (awaddr_reg == `IPCS_OFF_BAUD);
  wire rd_buf = rd_go & (araddr == `IPCS_OFF_BUF);
  wire wr_map = (awaddr_reg == `IPCS_OFF_STATUS) | (awaddr_reg == `IPCS_OFF_CTRL) |
                (awaddr_reg == `IPCS_OFF_BUF) | (awaddr_reg == `IPCS_OFF_BAUD);
  wire rd_map = (araddr == `IPCS_OFF_STATUS) | (araddr == `IPCS_OFF_CTRL) |
                (araddr == `IPCS_OFF_BUF) | (araddr == `IPCS_OFF_BAUD);

  // bus condition detection
  wire scl_rise = ~scl_d_reg & scl_in;
  wire scl_fall = scl_d_reg & ~scl_in;
  wire start_det = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
  wire stop_det = scl_in & scl_d_reg & ~sda_d_reg & sda_in;

  // byte engine terms
  wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
  wire rx_done = slv & ~stx_reg & scl_rise & (bitcnt_reg == 4'h7);
  wire tx_busy = mst ? (mtx_reg | s_reg) : (stx_reg & bf_reg);
  wire tx_mode = mst | (slv & stx_reg);
  wire write_collision_flag_set = wr_buf & tx_mode & tx_busy;
  wire ovf_set = rx_done & bf_reg;
  wire mtx_go = wr_buf & mst & ~tx_busy;
  wire stx_load = wr_buf & slv & stx_reg & ~tx_busy;
  wire tick = (qcnt_reg == {1'b0, baud_reg[6:0]});
  wire bit_live = (bitcnt_reg < `IPCS_BITS_BYTE);

  wire [7:0] stat_rd = {stat_wr_reg, da_reg, p_reg, s_reg, rw_reg, ua_reg, bf_reg};
  wire [7:0] ctl_rd = {write_collision_flag_reg, ovf_reg, en_reg, ckp_reg, mode_reg};

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channels: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= `IPCS_RST_BYTE;
      wbyte_reg <= `IPCS_RST_BYTE;
      wlane_reg <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `IPCS_RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid & wready) begin
        w_have_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_map ? `IPCS_RESP_OKAY : `IPCS_RESP_SLVERR;
      end
      if (bvalid & bready) begin
        bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // axi4-lite read channel: data registered on the same edge that takes the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `IPCS_RESP_OKAY;
    end else begin
      if (rd_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= rd_map ? `IPCS_RESP_OKAY : `IPCS_RESP_SLVERR;
        case (araddr)
          `IPCS_OFF_STATUS: rdata <= {24'h00_0000, stat_rd};
          `IPCS_OFF_CTRL:   rdata <= {24'h00_0000, ctl_rd};
          `IPCS_OFF_BUF:    rdata <= {24'h00_0000, buf_reg};
          `IPCS_OFF_BAUD:   rdata <= {24'h00_0000, baud_reg};
          default:          rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-held control and status fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_wr_reg <= 2'h0;
      write_collision_flag_reg <= 1'b0;
      ovf_reg <= 1'b0;
      en_reg <= 1'b0;
      mode_reg <= 4'h0;
      baud_reg <= `IPCS_RST_BYTE;
    end else begin
      if (wr_stat) begin
        stat_wr_reg <= wbyte_reg[7:6];
      end
      if (wr_ctl) begin
        en_reg <= wbyte_reg[`IPCS_CT_EN];
        mode_reg <= wbyte_reg[3:0];
      end
      // a hardware set in the same cycle as a software clear wins
      write_collision_flag_reg <= (wr_ctl ? wbyte_reg[`IPCS_CT_WRITE_COLLISION_FLAG] : write_collision_flag_reg) | write_collision_flag_set;
      ovf_reg <= (wr_ctl ? wbyte_reg[`IPCS_CT_OVF] : ovf_reg) | ovf_set;
      if (wr_baud) begin
        baud_reg <= wbyte_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus monitor, slave and master byte engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      buf_reg <= `IPCS_RST_BYTE;
      bf_reg <= 1'b0;
      ua_reg <= 1'b0;
      rw_reg <= 1'b0;
      s_reg <= 1'b0;
      p_reg <= 1'b0;
      da_reg <= 1'b0;
      ckp_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      bitcnt_reg <= 4'h0;
      shift_reg <= `IPCS_RST_BYTE;
      addr_ph_reg <= 1'b0;
      stx_reg <= 1'b0;
      mtx_reg <= 1'b0;
      phase_reg <= 2'h0;
      qcnt_reg <= `IPCS_RST_BYTE;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
      if (wr_ctl) begin
        ckp_reg <= wbyte_reg[`IPCS_CT_CKP];
      end
      if (wr_baud) begin
        ua_reg <= 1'b0;
      end
      if (wr_buf) begin
        buf_reg <= wbyte_reg;
      end
      // reading the buffer empties it; a byte landing the same cycle finds it still full, is not stored and sets overflow
      if (rd_buf) begin
        bf_reg <= 1'b0;
      end
      if (!en_reg) begin
        s_reg <= 1'b0;
        p_reg <= 1'b0;
        stx_reg <= 1'b0;
        mtx_reg <= 1'b0;
        addr_ph_reg <= 1'b0;
        bitcnt_reg <= 4'h0;
      end else begin
        // latest bus condition seen
        if (start_det) begin
          s_reg <= 1'b1;
          p_reg <= 1'b0;
        end else if (stop_det) begin
          p_reg <= 1'b1;
          s_reg <= 1'b0;
        end
        if (slv) begin
          if (start_det | stop_det) begin
            bitcnt_reg <= 4'h0;
            addr_ph_reg <= start_det;
            stx_reg <= 1'b0;
          end else if (scl_rise) begin
            if (bit_live) begin
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end else begin
              bitcnt_reg <= 4'h0;
              if (stx_reg & sda_in) begin
                stx_reg <= 1'b0; // not acknowledged: transmit ends
              end
            end
            if (!stx_reg & bit_live) begin
              shift_reg <= rx_byte;
            end
            if (stx_reg & (bitcnt_reg == 4'h7)) begin
              bf_reg <= 1'b0;
            end
          end else if (scl_fall & stx_reg & (bitcnt_reg != 4'h0) & bit_live) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
          if (rx_done) begin
            addr_ph_reg <= 1'b0;
            da_reg <= ~addr_ph_reg;
            if (addr_ph_reg) begin
              rw_reg <= sda_in;
              ua_reg <= ten_bit;
              stx_reg <= sda_in;
              if (sda_in) begin
                ckp_reg <= 1'b0; // stretch until software sets the clock-release bit
              end
            end
            if (!bf_reg) begin
              buf_reg <= rx_byte;
              bf_reg <= 1'b1;
            end
          end
          if (stx_load) begin
            shift_reg <= wbyte_reg;
            bf_reg <= 1'b1;
          end
        end
        if (mst) begin
          // quarter-period ticks every baud[6:0]+1 clocks (baud bit 7 unused), four per scl period
          qcnt_reg <= (tick | mtx_go) ? 8'h00 : qcnt_reg + 8'h01;
          if (mtx_go) begin
            shift_reg <= wbyte_reg;
            bf_reg <= 1'b1;
            mtx_reg <= 1'b1;
            rw_reg <= 1'b1;
            bitcnt_reg <= 4'h0;
            phase_reg <= 2'h0;
          end else if (mtx_reg & tick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3) begin
              bitcnt_reg <= bitcnt_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              if (!bit_live) begin
                mtx_reg <= 1'b0;
                rw_reg <= 1'b0;
                bf_reg <= 1'b0;
                bitcnt_reg <= 4'h0;
              end
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pin drive: low-only, enables follow the engine state
  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      pins_owned <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      pins_owned <= en_reg;
      // clock-release only stretches in slave modes; master ignores it
      scl_oe <= (slv & ~ckp_reg) | (mst & mtx_reg & ~phase_reg[1]);
      sda_oe <= ((slv & stx_reg & bf_reg) | (mst & mtx_reg)) & bit_live & ~shift_reg[7];
    end
  end

endmodule

// ### testbench/ipcs_bus_model.sv
// Purpose: another bus party on scl and sda, plus a monitor of scl rises
// Assumes: both lines have pull-ups; every party only pulls low
// Notes:   tasks are called from the testbench; half bit is 4 clocks
`timescale 1ns/1ps
module ipcs_bus_model (
  input  wire aclk,
  input  wire scl_oe,
  input  wire sda_oe,
  output wire scl_in,
  output wire sda_in
);
  logic       scl_low, sda_low, scl_q;
  logic [7:0] shr, byte_q;
  int         cnt;
  time        t0, t1;
  // wired-and lines, pins only ever act as inputs or open-drain pull-downs
  assign scl_in = !(scl_oe || scl_low);
  assign sda_in = !(sda_oe || sda_low);
  initial begin
    scl_low = 0;
    sda_low = 0;
    scl_q = 1;
    cnt = 0;
  end
  // shift sda on each scl rise, keep first eight bits and rise times
  always @(posedge aclk) begin
    scl_q <= scl_in;
    if (scl_in && !scl_q) begin
      shr <= {shr[6:0], sda_in};
      if (cnt == 7) byte_q <= {shr[6:0], sda_in};
      if (cnt == 0) t0 <= $time;
      t1 <= $time;
      cnt <= cnt + 1;
    end
  end
  task automatic clr;
    cnt <= 0;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic start;
    sda_low <= 1;
    hold(4);
    scl_low <= 1;
    hold(2);
  endtask
  // eight data bits msb first, ninth clock with sda left released
  task automatic send(input logic [7:0] b);
    logic [8:0] s;
    s = {b, 1'b1};
    repeat (9) begin
      sda_low <= !s[8];
      s = s << 1;
      hold(2);
      scl_low <= 0;
      hold(4);
      scl_low <= 1;
      hold(2);
    end
  endtask
  task automatic stop;
    sda_low <= 1;
    hold(2);
    scl_low <= 0;
    hold(4);
    sda_low <= 0;
    hold(4);
  endtask
endmodule

// ### testbench/ipcs_port_sva.sv
// Purpose: bus handshake and pin level checks on the i2c port block
// Assumes: single aclk domain, synchronous active-low reset
// Notes:   bound to the design from the testbench top file
`timescale 1ns/1ps
module ipcs_port_sva (
  input wire aclk,
  input wire aresetn,
  input wire awready,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire scl_out,
  input wire sda_out,
  input wire scl_oe,
  input wire sda_oe,
  input wire pins_owned
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // open-drain pins may only ever pull low
  a_drive_low: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  // pins handed back to general i/o stay released
  a_off_quiet: assert property (!pins_owned && !$past(pins_owned) && !$past(pins_owned, 2) |-> !scl_oe && !sda_oe)
    else $error("pin pulled while port disabled");
  // responses stand until taken, then drop and reopen the channels
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("read response dropped early");
  a_w_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during response");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read channel open during response");
  a_b_done: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write response not retired");
  a_r_done: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read response not retired");

  // main traffic seen
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_scl: cover property ($rose(scl_oe));
endmodule

// ### testbench/tb_i2c_port_control_status.sv
// Purpose: register and pin level tests of the i2c port block
// Assumes: axi4-lite master tasks, one clock at 40 MHz
// Notes:   partner model drives the far side of the pins
`timescale 1ns/1ps
`include "ipcs_map.vh"
module tb_i2c_port_control_status;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, scl_in, sda_in;
  logic        scl_out, scl_oe, sda_out, sda_oe, pins_owned;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lr;
  int          failures, tests_run, m, n;

  ipcs_port u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .pins_owned);
  ipcs_bus_model u_bus (.aclk, .scl_oe, .sda_oe, .scl_in, .sda_in);

  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    lr = rresp;
    rready <= 0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: whole run needs about 550 clocks
  initial begin
    #200_000;
    failures++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(`IPCS_OFF_STATUS, v); chk(v, 32'h0000_0000);
    rd(`IPCS_OFF_CTRL, v); chk(v, 32'h0000_0000);
    rd(8'h10, v); chk({30'h0, lr}, {30'h0, `IPCS_RESP_SLVERR});
    wr(`IPCS_OFF_STATUS, 32'h0000_00FF);
    rd(`IPCS_OFF_STATUS, v); chk(v, 32'h0000_00C0);
    wr(`IPCS_OFF_STATUS, 32'h0000_0000);
    // every mode code: slave codes hold scl with release bit 0, then let go
    for (m = 0; m < 16; m++) begin
      wr(`IPCS_OFF_CTRL, 32'h0000_0020 | m);
      repeat (3) @(posedge aclk);
      chk({31'h0, pins_owned}, 32'h0000_0001);
      chk({31'h0, scl_oe}, {31'h0, m inside {6, 7, 14, 15}});
      wr(`IPCS_OFF_CTRL, 32'h0000_0030 | m);
      repeat (3) @(posedge aclk);
      chk({31'h0, scl_oe}, 32'h0000_0000);
    end
    wr(`IPCS_OFF_CTRL, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk({31'h0, pins_owned}, 32'h0000_0000);
    // hardware master: quarter of 2 clocks, scl period of 8 clocks
    wr(`IPCS_OFF_BAUD, 32'h0000_0001);
    wr(`IPCS_OFF_CTRL, 32'h0000_0028);
    u_bus.clr;
    wr(`IPCS_OFF_BUF, 32'h0000_00A5);
    rd(`IPCS_OFF_STATUS, v); chk(v & 32'h0000_0007, 32'h0000_0005);
    wr(`IPCS_OFF_BUF, 32'h0000_005A);
    rd(`IPCS_OFF_CTRL, v); chk(v, 32'h0000_00A8);
    for (n = 0; n < 300 && u_bus.cnt < 9; n++) @(posedge aclk);
    repeat (12) @(posedge aclk);
    chk(32'(u_bus.cnt), 32'h0000_0009);
    chk(32'(u_bus.t1 - u_bus.t0), 32'h0000_0640);
    chk({24'h0, u_bus.byte_q}, 32'h0000_00A5);
    rd(`IPCS_OFF_STATUS, v); chk(v & 32'h0000_0007, 32'h0000_0000);
    wr(`IPCS_OFF_CTRL, 32'h0000_0000);
    // slave receive: address then a byte that finds the buffer full
    wr(`IPCS_OFF_CTRL, 32'h0000_0036);
    u_bus.start;
    u_bus.send(8'h54);
    u_bus.send(8'h3C);
    rd(`IPCS_OFF_STATUS, v); chk(v & 32'h0000_001F, 32'h0000_0009);
    rd(`IPCS_OFF_CTRL, v); chk(v, 32'h0000_0076);
    rd(`IPCS_OFF_BUF, v); chk(v, 32'h0000_0054);
    rd(`IPCS_OFF_STATUS, v); chk(v & 32'h0000_001F, 32'h0000_0008);
    u_bus.stop;
    rd(`IPCS_OFF_STATUS, v); chk(v & 32'h0000_001F, 32'h0000_0010);
    wr(`IPCS_OFF_CTRL, 32'h0000_0006);
    // the last byte taken was data, so the data/address bit stays set after disable
    rd(`IPCS_OFF_STATUS, v); chk(v, 32'h0000_0020);
    tally_and_finish;
  end
endmodule

bind ipcs_port ipcs_port_sva u_sva (.aclk, .aresetn, .awready, .wready, .bvalid, .bready,
  .arready, .rvalid, .rready, .scl_out, .sda_out, .scl_oe, .sda_oe, .pins_owned);
